/* File: hdl/cbadc_counters.sv */
// Clock counter and data counter of the conversion window.
// Assumes clear and enable come from the sequencer on the same clock.
`include "cbadc_defs.svh"
module cbadc_counters #(
    parameter int WINDOW_CYC = `CBADC_WINDOW_CYC
) (
    input  wire logic clk,
    input  wire logic rst_n,
    cbadc_cnt_if.cnt  cif
);
    import cbadc_pkg::*;

    logic [31:0]    clk_cnt_r;
    logic [31:0]    clk_cnt_nxt;
    cbadc_word_type data_cnt_r;
    cbadc_word_type data_cnt_nxt;
    logic           ovf_r;
    logic           ovf_nxt;

    always_comb begin
        clk_cnt_nxt  = clk_cnt_r;
        data_cnt_nxt = data_cnt_r;
        ovf_nxt      = ovf_r;
        if (cif.clear) begin
            clk_cnt_nxt  = '0;
            data_cnt_nxt = '0;
            ovf_nxt      = 1'b0;
        end else if (cif.enable) begin
            clk_cnt_nxt = clk_cnt_r + 32'h1;
            if (cif.ref_pulse) begin
                // Saturate instead of wrapping so overrange reads all ones
                if (&data_cnt_r) begin
                    ovf_nxt = 1'b1;
                end else begin
                    data_cnt_nxt = data_cnt_r + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clk_cnt_r  <= '0;
            data_cnt_r <= '0;
            ovf_r      <= 1'b0;
        end else begin
            clk_cnt_r  <= clk_cnt_nxt;
            data_cnt_r <= data_cnt_nxt;
            ovf_r      <= ovf_nxt;
        end
    end

    assign cif.clk_terminal  = (clk_cnt_r >= 32'(WINDOW_CYC - 1));
    assign cif.data_overflow = ovf_r;
    assign cif.total         = data_cnt_r;
endmodule // cbadc_counters

/* File: hdl/cbadc_seq.sv */
// Top of the charge-balance converter sequencer: phases, result latch, status.
// Assumes comparator_high is an asynchronous analog comparator level.
`include "cbadc_defs.svh"
// How it works
// - Result is a twelve-bit unsigned binary word on the parallel outputs.
// - A conversion takes about 20 ms, never above 24 ms.
// - Free-running, at least 42 and typically 50 conversions each second.
// - Reference current applied one clock per pulse while integrator needs rebalancing.
// - Clock counter starts after reset pulse; terminal count starts end sequence.
// - Data counter cleared with clock counter, counts each reference pulse.
// - At conversion end the data total moves into the output latches.
// - Request while idle raises busy, 10 us start-up discharges and clears counters.
// - Counting ends at clock counter terminal or data counter overflow.
// - End pulse stops both counters and begins a 10 us shutdown.
// - Result valid low about 5 us during shutdown while latches load.
// - Request ignored while busy; a started conversion always completes.
// - Latched data holds until result valid falls in a later conversion.
// - Busy high through conversion; fall means latched, rise means started.
// - Free-running, busy stays low about 2.5 us between conversions.
// - Result valid high means outputs hold latest completed result.
// - Output enable high floats result outputs; low drives latched word.
// - Result saturates at all ones or zeros, never wraps.
module cbadc_seq #(
    parameter int STARTUP_CYC  = `CBADC_STARTUP_CYC,
    parameter int SHUTDOWN_CYC = `CBADC_SHUTDOWN_CYC,
    parameter int INVALID_CYC  = `CBADC_INVALID_CYC,
    parameter int GAP_CYC      = `CBADC_GAP_CYC,
    parameter int WINDOW_CYC   = `CBADC_WINDOW_CYC
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                conversion_request,
    input  wire logic                comparator_high,
    input  wire logic                output_drive_enable,
    output logic                     ref_switch,
    output logic                     integrator_discharge,
    output logic                     busy,
    output logic                     result_valid,
    output cbadc_pkg::cbadc_word_type result_out,
    output cbadc_pkg::cbadc_word_type result_oe
);
    import cbadc_pkg::*;

    cbadc_cnt_if cif ();

    cbadc_counters #(
        .WINDOW_CYC (WINDOW_CYC)
    ) u_counters (
        .clk   (clk),
        .rst_n (rst_n),
        .cif   (cif)
    );

    // Two-stage synchronisers for pin inputs, one pair of flops per pin
    localparam int PIN_CNT = 3;
    logic [PIN_CNT-1:0] pin_raw;
    logic [PIN_CNT-1:0] sync1_r;
    logic [PIN_CNT-1:0] sync1_nxt;
    logic [PIN_CNT-1:0] sync2_r;
    logic [PIN_CNT-1:0] sync2_nxt;
    assign pin_raw = {output_drive_enable, comparator_high, conversion_request};

    genvar pin_i;
    generate
        for (pin_i = 0; pin_i < PIN_CNT; pin_i++) begin : g_sync
            // Only the second stage reads the first, so no logic sees a metastable level
            always_comb begin
                sync1_nxt[pin_i] = pin_raw[pin_i];
                sync2_nxt[pin_i] = sync1_r[pin_i];
            end
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    sync1_r[pin_i] <= 1'b0;
                    sync2_r[pin_i] <= 1'b0;
                end else begin
                    sync1_r[pin_i] <= sync1_nxt[pin_i];
                    sync2_r[pin_i] <= sync2_nxt[pin_i];
                end
            end
        end
    endgenerate
    logic req_s;
    logic cmp_s;
    logic oe_n_s;
    assign req_s  = sync2_r[0];
    assign cmp_s  = sync2_r[1];
    assign oe_n_s = sync2_r[2];

    cbadc_state_type state_r;
    cbadc_state_type state_nxt;
    logic [31:0]     phase_r;
    logic [31:0]     phase_nxt;
    logic            busy_r;
    logic            busy_nxt;
    logic            valid_r;
    logic            valid_nxt;
    logic            dis_r;
    logic            dis_nxt;
    logic            ref_r;
    logic            ref_nxt;
    cbadc_word_type  latch_r;
    cbadc_word_type  latch_nxt;
    cbadc_word_type  out_r;
    cbadc_word_type  out_nxt;
    cbadc_word_type  oe_r;
    cbadc_word_type  oe_nxt;
    logic            end_hit;
    logic            start_go;
    logic            load_go;
    logic            done_go;
    logic            lost_go;

    // Window ends on terminal count or data overflow, whichever first
    assign end_hit = cif.clk_terminal || cif.data_overflow;

    always_comb begin
        state_nxt = state_r;
        phase_nxt = phase_r + 32'h1;
        dis_nxt   = 1'b0;
        ref_nxt   = 1'b0;
        start_go  = 1'b0;
        load_go   = 1'b0;
        done_go   = 1'b0;
        lost_go   = 1'b0;
        cif.clear     = 1'b0;
        cif.enable    = 1'b0;
        cif.ref_pulse = ref_r;
        case (state_r)
            CBADC_IDLE: begin
                phase_nxt = '0;
                if (req_s) begin
                    state_nxt = CBADC_STARTUP;
                    start_go  = 1'b1;
                    dis_nxt   = 1'b1;
                end
            end
            CBADC_STARTUP: begin
                dis_nxt   = 1'b1;
                cif.clear = 1'b1;
                if (phase_r >= 32'(STARTUP_CYC - 1)) begin
                    state_nxt = CBADC_COUNT;
                    phase_nxt = '0;
                    dis_nxt   = 1'b0;
                end
            end
            CBADC_COUNT: begin
                cif.enable = 1'b1;
                // One-clock reference pulse, at most every other clock, while the integrator sits high
                ref_nxt = cmp_s && !ref_r && !end_hit;
                if (end_hit) begin
                    state_nxt = CBADC_SHUTDOWN;
                    phase_nxt = '0;
                    ref_nxt   = 1'b0;
                end
            end
            CBADC_SHUTDOWN: begin
                // Counters frozen: enable stays low here
                cif.ref_pulse = 1'b0;
                if (phase_r == 32'(SHUTDOWN_CYC - INVALID_CYC - 1)) begin
                    load_go   = 1'b1;
                end
                if (phase_r >= 32'(SHUTDOWN_CYC - 1)) begin
                    done_go   = 1'b1;
                    state_nxt = CBADC_GAP;
                    phase_nxt = '0;
                end
            end
            CBADC_GAP: begin
                // Request is not looked at until this gap ends
                if (phase_r >= 32'(GAP_CYC - 1)) begin
                    state_nxt = CBADC_IDLE;
                    phase_nxt = '0;
                end
            end
            default: begin
                state_nxt = CBADC_IDLE;
                phase_nxt = '0;
                lost_go   = 1'b1;
            end
        endcase
    end

    // Status group: busy and result-valid
    always_comb begin
        busy_nxt  = busy_r;
        valid_nxt = valid_r;
        if (start_go) begin
            busy_nxt = 1'b1;
        end
        if (load_go) begin
            valid_nxt = 1'b0;
        end
        // Both change together so the busy fall already means latched
        if (done_go) begin
            valid_nxt = 1'b1;
            busy_nxt  = 1'b0;
        end
        if (lost_go) begin
            busy_nxt = 1'b0;
        end
    end

    // Latch group: only the shutdown load point touches the result
    always_comb begin
        latch_nxt = latch_r;
        if (load_go) begin
            latch_nxt = cif.total;
        end
    end

    // The GAP state holds busy low after every conversion, free-run or strobed
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= CBADC_IDLE;
            phase_r <= '0;
            dis_r   <= 1'b0;
            ref_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            phase_r <= phase_nxt;
            dis_r   <= dis_nxt;
            ref_r   <= ref_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_r  <= 1'b0;
            valid_r <= 1'b0;
        end else begin
            busy_r  <= busy_nxt;
            valid_r <= valid_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            latch_r <= '0;
        end else begin
            latch_r <= latch_nxt;
        end
    end

    // Bus group: each result bit and its driver enable come from their own flops
    genvar bit_i;
    generate
        for (bit_i = 0; bit_i < `CBADC_RESULT_BITS; bit_i++) begin : g_bus
            // Driver floats while the enable pin is high
            always_comb begin
                out_nxt[bit_i] = latch_nxt[bit_i];
                oe_nxt[bit_i]  = !oe_n_s;
            end
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    out_r[bit_i] <= 1'b0;
                    oe_r[bit_i]  <= 1'b0;
                end else begin
                    out_r[bit_i] <= out_nxt[bit_i];
                    oe_r[bit_i]  <= oe_nxt[bit_i];
                end
            end
        end
    endgenerate

    // Conversion length is at most window plus start-up and shutdown: about 20 ms at
    // defaults, well inside 24 ms, giving about 50 per second free-running.
    assign ref_switch           = ref_r;
    assign integrator_discharge = dis_r;
    assign busy                 = busy_r;
    assign result_valid         = valid_r;
    assign result_out           = out_r;
    assign result_oe            = oe_r;
endmodule // cbadc_seq

/* File: shared/cbadc_cnt_if.sv */
// Control and status between the sequencer and its counter pair.
// Assumes one clock domain; no clocking block.
interface cbadc_cnt_if;
    logic                   clear;
    logic                   enable;
    logic                   ref_pulse;
    logic                   clk_terminal;
    logic                   data_overflow;
    cbadc_pkg::cbadc_word_type total;
    modport seq (output clear, output enable, output ref_pulse,
                 input clk_terminal, input data_overflow, input total);
    modport cnt (input clear, input enable, input ref_pulse,
                 output clk_terminal, output data_overflow, output total);
endinterface

/* File: shared/cbadc_defs.svh */
// Timing and width constants for the charge-balance converter sequencer.
// Assumes a 10 MHz core clock; included by the package and design files.
`ifndef CBADC_DEFS_SVH
`define CBADC_DEFS_SVH
`define CBADC_CLK_PERIOD_NS     100
`define CBADC_RESULT_BITS       12
`define CBADC_STARTUP_NS        10000
`define CBADC_SHUTDOWN_NS       10000
`define CBADC_INVALID_NS        5000
`define CBADC_GAP_NS            2500
`define CBADC_WINDOW_NS         20000000
`define CBADC_STARTUP_CYC       ((`CBADC_STARTUP_NS + `CBADC_CLK_PERIOD_NS - 1) / `CBADC_CLK_PERIOD_NS)
`define CBADC_SHUTDOWN_CYC      ((`CBADC_SHUTDOWN_NS + `CBADC_CLK_PERIOD_NS - 1) / `CBADC_CLK_PERIOD_NS)
`define CBADC_INVALID_CYC       ((`CBADC_INVALID_NS + `CBADC_CLK_PERIOD_NS - 1) / `CBADC_CLK_PERIOD_NS)
`define CBADC_GAP_CYC           ((`CBADC_GAP_NS + `CBADC_CLK_PERIOD_NS - 1) / `CBADC_CLK_PERIOD_NS)
`define CBADC_WINDOW_CYC        (`CBADC_WINDOW_NS / `CBADC_CLK_PERIOD_NS)
`endif

/* File: shared/cbadc_pkg.sv */
// Types shared by the converter sequencer and its counter pair.
// Assumes cbadc_defs.svh is on the include path.
`include "cbadc_defs.svh"
package cbadc_pkg;
    typedef enum logic [2:0] {
        CBADC_IDLE,
        CBADC_STARTUP,
        CBADC_COUNT,
        CBADC_SHUTDOWN,
        CBADC_GAP
    } cbadc_state_type;
    typedef logic [`CBADC_RESULT_BITS-1:0] cbadc_word_type;
endpackage

/* File: test/cbadc_assertions.sv */
// Checker on the ports of the converter sequencer top.
// Assumes a single clock and bind onto cbadc_seq.
module cbadc_assertions
    import cbadc_pkg::*;
#(
    parameter int STARTUP_CYC  = 4,
    parameter int SHUTDOWN_CYC = 8,
    parameter int INVALID_CYC  = 4,
    parameter int GAP_CYC      = 2,
    parameter int WINDOW_CYC   = 64
) (
    input wire logic                      clk,
    input wire logic                      rst_n,
    input wire logic                      output_drive_enable,
    input wire logic                      ref_switch,
    input wire logic                      integrator_discharge,
    input wire logic                      busy,
    input wire logic                      result_valid,
    input wire cbadc_pkg::cbadc_word_type result_out,
    input wire cbadc_pkg::cbadc_word_type result_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int INV_MAX = INVALID_CYC + 2;
    logic [15:0] bsy_r;
    logic [15:0] low_r;
    logic [15:0] dis_r;
    logic [1:0]  up_r;
    // Idle count starts saturated so the first start after reset is not judged
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bsy_r <= 16'h0000;
            low_r <= 16'hFFFF;
            dis_r <= 16'h0000;
            up_r  <= 2'h0;
        end else begin
            bsy_r <= busy ? bsy_r + 16'h0001 : 16'h0000;
            low_r <= busy ? 16'h0000 : (low_r == 16'hFFFF ? low_r : low_r + 16'h0001);
            dis_r <= integrator_discharge ? dis_r + 16'h0001 : 16'h0000;
            up_r  <= (up_r == 2'h3) ? up_r : up_r + 2'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_ref_single: assert property (ref_switch |=> !ref_switch)
        else $error("reference pulse longer than one clock");
    chk_ref_window: assert property (ref_switch |-> busy && !integrator_discharge)
        else $error("reference pulse outside counting");
    chk_start_pair: assert property ($rose(busy) |-> $rose(integrator_discharge))
        else $error("start without discharge");
    chk_start_len: assert property ($fell(integrator_discharge) |-> dis_r == STARTUP_CYC)
        else $error("start-up length wrong");
    chk_data_hold: assert property ($changed(result_out) |-> !result_valid && busy)
        else $error("result changed while valid");
    chk_valid_end: assert property ($rose(result_valid) |-> $fell(busy))
        else $error("valid rose apart from busy fall");
    chk_invalid_len: assert property ($fell(result_valid) |-> busy ##[1:INV_MAX] $rose(result_valid))
        else $error("invalid interval wrong");
    chk_busy_len: assert property ($fell(busy) |-> bsy_r >= STARTUP_CYC + SHUTDOWN_CYC
        && bsy_r <= STARTUP_CYC + WINDOW_CYC + SHUTDOWN_CYC + 2)
        else $error("conversion length wrong");
    chk_gap_min: assert property ($rose(busy) |-> low_r >= GAP_CYC)
        else $error("busy gap too short");
    chk_oe_follow: assert property (up_r == 2'h3 |-> result_oe == {12{!$past(output_drive_enable, 3)}})
        else $error("output enable wrong");
endmodule // cbadc_assertions
bind cbadc_seq cbadc_assertions #(.STARTUP_CYC(STARTUP_CYC), .SHUTDOWN_CYC(SHUTDOWN_CYC),
    .INVALID_CYC(INVALID_CYC), .GAP_CYC(GAP_CYC), .WINDOW_CYC(WINDOW_CYC)) u_chk (.clk(clk),
    .rst_n(rst_n), .output_drive_enable(output_drive_enable), .ref_switch(ref_switch),
    .integrator_discharge(integrator_discharge), .busy(busy), .result_valid(result_valid),
    .result_out(result_out), .result_oe(result_oe));

/* File: test/cbadc_host_model.sv */
// Host reading the result bus at each busy fall.
// Assumes the bench drives request and output enable.
module cbadc_host_model (
    input  wire logic                      clk,
    input  wire logic                      busy,
    input  wire logic                      result_valid,
    input  wire cbadc_pkg::cbadc_word_type result_out,
    input  wire cbadc_pkg::cbadc_word_type result_oe,
    output cbadc_pkg::cbadc_word_type      rd_word,
    output int                             n_done
);
    timeunit 1ns;
    timeprecision 1ns;
    import cbadc_pkg::*;
    logic           busy_d = 1'b0;
    cbadc_word_type last_r = '0;
    cbadc_word_type bus_w;
    // A floating bit shows the inverse of its last level, never a kind guess
    assign bus_w = (result_oe & result_out) | (~result_oe & ~last_r);
    initial n_done = 0;
    always @(posedge clk) begin
        last_r <= bus_w;
        busy_d <= busy;
        if (busy_d && !busy && result_valid) begin
            rd_word <= bus_w;
            n_done <= n_done + 1;
        end
    end
endmodule // cbadc_host_model

/* File: test/cbadc_seq_tb.sv */
// Self-checking bench for the converter sequencer.
// Assumes short phases and a window long enough to overflow.
module cbadc_seq_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import cbadc_pkg::*;
    localparam int WIN = 9000;
    logic           clk = 0, rst_n = 0, req = 0, cmp = 0, odis = 0;
    logic           ref_sw, dis, busy, valid;
    cbadc_word_type res, oe, rd;
    int             n_done, num_errors = 0, n_tests = 0;
    logic [15:0]    last_exp = 16'h0000;
    initial forever #50 clk = ~clk;
    cbadc_seq #(.STARTUP_CYC(4), .SHUTDOWN_CYC(8), .INVALID_CYC(4), .GAP_CYC(2), .WINDOW_CYC(WIN)) dut_u (
        .clk(clk), .rst_n(rst_n), .conversion_request(req), .comparator_high(cmp),
        .output_drive_enable(odis), .ref_switch(ref_sw), .integrator_discharge(dis), .busy(busy),
        .result_valid(valid), .result_out(res), .result_oe(oe));
    cbadc_host_model host_u (.clk(clk), .busy(busy), .result_valid(valid), .result_out(res),
        .result_oe(oe), .rd_word(rd), .n_done(n_done));
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wait_busy(input logic lvl, input int lim);
        for (int i = 0; i < lim && busy !== lvl; i++) @(negedge clk);
        if (busy !== lvl) begin
            num_errors++;
            $display("wrong value busy wait expected %b seen %b", lvl, busy);
            end_of_test();
        end
    endtask
    // Mode 0 input zero, 1 partial, 2 beyond full scale
    task automatic convert(input int mode);
        int pulses;
        int cyc;
        pulses = 0;
        cyc = 0;
        cmp = (mode != 0);
        req = 1'b1;
        wait_busy(1'b1, 10);
        req = 1'b0;
        while (busy === 1'b1 && cyc < 2 * WIN) begin
            @(negedge clk);
            cyc++;
            pulses += int'(ref_sw === 1'b1);
            if (cyc == 50) check("held", last_exp, {4'h0, res});
            req = (cyc >= 100 && cyc < 110);
            if (mode == 1 && cyc == 600) cmp = 1'b0;
        end
        cmp = 1'b0;
        last_exp = (pulses > 4095) ? 16'h0FFF : 16'(pulses);
        check("result", last_exp, {4'h0, res});
        // Host takes the word at the edge after busy falls
        @(negedge clk);
        check("host", last_exp, {4'h0, rd});
        check("valid", 16'h0001, {15'h0000, valid});
        check("length", 16'h0001, {15'h0000, (mode == 2) ? cyc < WIN : cyc <= WIN + 20});
        repeat (10) @(negedge clk);
        check("no restart", 16'h0000, {15'h0000, busy});
    endtask
    task automatic t_oe();
        odis = 1'b1;
        repeat (5) @(negedge clk);
        check("oe off", 16'h0000, {4'h0, oe});
        odis = 1'b0;
        repeat (5) @(negedge clk);
        check("oe on", 16'h0FFF, {4'h0, oe});
    endtask
    task automatic t_free();
        int gap;
        int n0;
        gap = 0;
        n0 = n_done;
        req = 1'b1;
        wait_busy(1'b1, 10);
        wait_busy(1'b0, 2 * WIN);
        while (busy === 1'b0 && gap < 20) begin
            @(negedge clk);
            gap++;
        end
        check("gap", 16'h0001, {15'h0000, gap >= 2 && gap <= 8});
        wait_busy(1'b0, 2 * WIN);
        req = 1'b0;
        repeat (2) @(negedge clk);
        check("runs", 16'(n0 + 2), 16'(n_done));
    endtask
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        check("reset", 16'h0000, {busy, valid, ref_sw, dis, res});
        convert(0);
        convert(1);
        convert(2);
        t_oe();
        t_free();
        end_of_test();
    end
endmodule // cbadc_seq_tb
